// ===== include/bdre_pkg.sv
// Package with constants and types for the descriptor ring engine.
package bdre_pkg;
   localparam int BDRE_RING_LEN = 8;
   localparam int BDRE_IDX_W = 3;
   localparam int BDRE_MEM_AW = 6;
   localparam logic [3:0] BDRE_DESC_WORDS = 4'h4;
   localparam logic [BDRE_MEM_AW-1:0] BDRE_RX_BASE = 6'h00;
   localparam logic [BDRE_MEM_AW-1:0] BDRE_TX_BASE = 6'h20;
   localparam int BDRE_OWN_BIT = 15;
   localparam int BDRE_WRAP_BIT = 13;
   localparam int BDRE_W_CTRL = 0;
   localparam int BDRE_W_LEN = 1;
   localparam int BDRE_W_PTR = 2;
   localparam logic [7:0] BDRE_A_CTRL = 8'h00;
   localparam logic [7:0] BDRE_A_EVENT = 8'h04;
   localparam logic [7:0] BDRE_A_MASK = 8'h08;
   localparam logic [7:0] BDRE_A_STATUS = 8'h0C;
   localparam logic [7:0] BDRE_A_MRBL = 8'h10;
   localparam logic [7:0] BDRE_A_DESC = 8'h80;
   localparam int BDRE_EV_RXB = 0;
   localparam int BDRE_EV_TXB = 1;
   localparam int BDRE_EV_BSY = 2;
   localparam int BDRE_EV_RXF = 3;
   localparam int BDRE_EV_TXE = 4;
   localparam int BDRE_EV_CD = 5;
   localparam int BDRE_EV_CTS = 6;
   localparam int BDRE_EV_W = 7;
   localparam logic [15:0] BDRE_MRBL_RST = 16'h0008;
   localparam logic [15:0] BDRE_ZERO16 = 16'h0000;
   typedef enum logic [2:0] {
      BDRE_IDLE = 3'b000,
      BDRE_TX_POLL = 3'b001,
      BDRE_TX_LEN = 3'b010,
      BDRE_TX_PTR = 3'b011,
      BDRE_TX_DATA = 3'b100,
      BDRE_TX_CLOSE = 3'b101,
      BDRE_RX_WORD = 3'b110,
      BDRE_RX_CLOSE = 3'b111
   } bdre_state_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
      logic eof;
      logic err;
   } bdre_rx_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
      logic last;
   } bdre_tx_t;
endpackage

// ===== rtl/bdre_engine.sv
// Descriptor ring engine moving serial channel data to and from buffers.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module bdre_engine
   import bdre_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire bdre_rx_t rx_in,
   output logic rx_ready,
   output bdre_tx_t tx_out,
   input wire logic tx_ready,
   input wire logic tx_err,
   input wire logic carrier_detect,
   input wire logic clear_to_send,
   output logic irq
);
   bdre_state_t st_q, st_d;
   logic [BDRE_IDX_W-1:0] tx_current_desc_ptr_q, tx_current_desc_ptr_d;
   logic [BDRE_IDX_W-1:0] rx_current_desc_ptr_q, rx_current_desc_ptr_d;
   logic [15:0] ctrl_w_q, ctrl_w_d, len_q, len_d, cnt_q, cnt_d, bptr_q, bptr_d;
   logic rx_close_q, rx_close_d, rx_open_q, rx_open_d, rx_eof_q, rx_eof_d;
   logic rx_fetch_q, rx_fetch_d;
   logic [1:0] ctl_q, ctl_d;
   logic [BDRE_EV_W-1:0] ev_q, ev_d, mask_q, mask_d, ev_set;
   logic [15:0] mrbl_q, mrbl_d, rdata_q, rdata_d;
   logic cd_q, cts_q, txv_q, txv_d, txl_q, txl_d, rd_desc_q;
   logic [15:0] txd_q, txd_d;
   logic bw_we, bus_desc;
   logic [BDRE_MEM_AW-1:0] b_addr, a_addr;
   logic [15:0] b_wdata, b_rdata, a_rdata;
   bdre_state_t ret_st;

   // Descriptor memory: port A for software, port B for the engine.
   assign bus_desc = (reg_addr >= BDRE_A_DESC);
   assign a_addr = reg_addr[BDRE_MEM_AW:1];

   bdre_mem bdre_mem_i (
      .clk(clk),
      .a_we(reg_wr && bus_desc),
      .a_addr(a_addr),
      .a_wdata(reg_wdata),
      .a_rdata(a_rdata),
      .b_we(bw_we),
      .b_addr(b_addr),
      .b_wdata(b_wdata),
      .b_rdata(b_rdata)
   );

   function automatic logic [BDRE_MEM_AW-1:0] desc_addr(
      input logic [BDRE_MEM_AW-1:0] base,
      input logic [BDRE_IDX_W-1:0] idx,
      input int word
   );
      desc_addr = base + BDRE_MEM_AW'(idx * BDRE_DESC_WORDS) + BDRE_MEM_AW'(word);
   endfunction

   function automatic logic [BDRE_IDX_W-1:0] next_idx(
      input logic [BDRE_IDX_W-1:0] idx,
      input logic [15:0] ctrl
   );
      next_idx = ctrl[BDRE_WRAP_BIT] ? '0 : idx + 1'b1;
   endfunction

   always_comb begin
      st_d = st_q;
      tx_current_desc_ptr_d = tx_current_desc_ptr_q;
      rx_current_desc_ptr_d = rx_current_desc_ptr_q;
      ctrl_w_d = ctrl_w_q;
      len_d = len_q;
      cnt_d = cnt_q;
      bptr_d = bptr_q;
      rx_close_d = rx_close_q;
      rx_open_d = rx_open_q;
      rx_eof_d = rx_eof_q;
      rx_fetch_d = rx_fetch_q;
      txv_d = txv_q && !tx_ready;
      txl_d = txl_q;
      txd_d = txd_q;
      ev_set = '0;
      bw_we = 1'b0;
      b_wdata = BDRE_ZERO16;
      b_addr = desc_addr(BDRE_TX_BASE, tx_current_desc_ptr_q, BDRE_W_CTRL);
      rx_ready = 1'b0;
      ret_st = ctl_q[0] ? BDRE_TX_POLL : BDRE_IDLE;
      unique case (st_q)
         BDRE_IDLE: begin
            // Receive has priority; memory read of tx control runs meanwhile.
            if (ctl_q[1] && rx_in.valid) begin
               st_d = BDRE_RX_WORD;
               b_addr = desc_addr(BDRE_RX_BASE, rx_current_desc_ptr_q, BDRE_W_CTRL);
            end else if (ctl_q[0]) begin
               st_d = BDRE_TX_POLL;
            end
         end
         BDRE_TX_POLL: begin
            b_addr = desc_addr(BDRE_TX_BASE, tx_current_desc_ptr_q, BDRE_W_LEN);
            if (ctl_q[1] && rx_in.valid) begin
               st_d = BDRE_IDLE;
            end else if (!ctl_q[0]) begin
               st_d = BDRE_IDLE;
            end else if (b_rdata[BDRE_OWN_BIT] && !rx_open_q) begin
               // An open receive buffer owns the shared work registers until it closes.
               ctrl_w_d = b_rdata;
               st_d = BDRE_TX_LEN;
            end else begin
               b_addr = desc_addr(BDRE_TX_BASE, tx_current_desc_ptr_q, BDRE_W_CTRL);
               st_d = BDRE_TX_POLL;
            end
         end
         BDRE_TX_LEN: begin
            b_addr = desc_addr(BDRE_TX_BASE, tx_current_desc_ptr_q, BDRE_W_PTR);
            len_d = b_rdata;
            cnt_d = BDRE_ZERO16;
            st_d = BDRE_TX_PTR;
         end
         BDRE_TX_PTR: begin
            bptr_d = b_rdata;
            b_addr = BDRE_MEM_AW'(b_rdata);
            st_d = (len_q == BDRE_ZERO16) ? BDRE_TX_CLOSE : BDRE_TX_DATA;
         end
         BDRE_TX_DATA: begin
            b_addr = BDRE_MEM_AW'(bptr_q + (cnt_q >> 1));
            if (!txv_q) begin
               txv_d = 1'b1;
               txd_d = b_rdata;
               cnt_d = cnt_q + 16'h0002;
               txl_d = (cnt_q + 16'h0002) >= len_q;
               b_addr = BDRE_MEM_AW'(bptr_q + ((cnt_q + 16'h0002) >> 1));
               if ((cnt_q + 16'h0002) >= len_q) begin
                  st_d = BDRE_TX_CLOSE;
               end
            end
         end
         BDRE_TX_CLOSE: begin
            bw_we = 1'b1;
            b_wdata = ctrl_w_q & ~(16'h0001 << BDRE_OWN_BIT);
            tx_current_desc_ptr_d = next_idx(tx_current_desc_ptr_q, ctrl_w_q);
            ev_set[BDRE_EV_TXB] = 1'b1;
            st_d = BDRE_IDLE;
         end
         BDRE_RX_WORD: begin
            // b_rdata holds the control word on entry and the buffer pointer after a fetch.
            if (!rx_open_q && !b_rdata[BDRE_OWN_BIT]) begin
               ev_set[BDRE_EV_BSY] = 1'b1;
               st_d = BDRE_IDLE;
            end else if (!rx_open_q) begin
               ctrl_w_d = b_rdata;
               cnt_d = BDRE_ZERO16;
               rx_open_d = 1'b1;
               rx_fetch_d = 1'b1;
               b_addr = desc_addr(BDRE_RX_BASE, rx_current_desc_ptr_q, BDRE_W_PTR);
            end else if (rx_fetch_q) begin
               bptr_d = b_rdata;
               rx_fetch_d = 1'b0;
            end else begin
               rx_ready = 1'b1;
               b_addr = BDRE_MEM_AW'(bptr_q + (cnt_q >> 1));
               bw_we = 1'b1;
               b_wdata = rx_in.data;
               cnt_d = cnt_q + 16'h0002;
               rx_eof_d = rx_in.eof;
               if (rx_in.eof || rx_in.err || (cnt_d >= mrbl_q)) begin
                  st_d = BDRE_RX_CLOSE;
               end else begin
                  st_d = ret_st;
               end
            end
         end
         BDRE_RX_CLOSE: begin
            bw_we = 1'b1;
            b_addr = desc_addr(BDRE_RX_BASE, rx_current_desc_ptr_q, BDRE_W_LEN);
            b_wdata = cnt_q;
            if (!rx_close_q) begin
               rx_close_d = 1'b1;
            end else begin
               b_addr = desc_addr(BDRE_RX_BASE, rx_current_desc_ptr_q, BDRE_W_CTRL);
               b_wdata = ctrl_w_q & ~(16'h0001 << BDRE_OWN_BIT);
               rx_current_desc_ptr_d = next_idx(rx_current_desc_ptr_q, ctrl_w_q);
               ev_set[BDRE_EV_RXB] = 1'b1;
               ev_set[BDRE_EV_RXF] = rx_eof_q;
               rx_close_d = 1'b0;
               rx_open_d = 1'b0;
               st_d = BDRE_IDLE;
            end
         end
         default: st_d = BDRE_IDLE;
      endcase
      ev_set[BDRE_EV_TXE] = tx_err;
      ev_set[BDRE_EV_CD] = carrier_detect ^ cd_q;
      ev_set[BDRE_EV_CTS] = clear_to_send ^ cts_q;
      if (!ctl_q[0]) begin
         tx_current_desc_ptr_d = '0;
      end
      if (!ctl_q[1]) begin
         rx_current_desc_ptr_d = '0;
      end
   end

   // Receive buffer pointer is fetched in BDRE_RX_WORD and cleared while idle with no buffer open.
   always_comb begin
      ctl_d = ctl_q;
      mask_d = mask_q;
      mrbl_d = mrbl_q;
      rdata_d = BDRE_ZERO16;
      ev_d = ev_q;
      if (reg_wr && reg_addr == BDRE_A_CTRL) begin
         ctl_d = reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == BDRE_A_MASK) begin
         mask_d = reg_wdata[BDRE_EV_W-1:0];
      end
      if (reg_wr && reg_addr == BDRE_A_MRBL) begin
         mrbl_d = reg_wdata;
      end
      if (reg_wr && reg_addr == BDRE_A_EVENT) begin
         ev_d = ev_q & ~reg_wdata[BDRE_EV_W-1:0];
      end
      ev_d = ev_d | ev_set;
      if (reg_rd) begin
         unique case (reg_addr)
            BDRE_A_CTRL: rdata_d = {14'h0000, ctl_q};
            BDRE_A_EVENT: rdata_d = {8'h00, 1'b0, ev_q};
            BDRE_A_MASK: rdata_d = {8'h00, 1'b0, mask_q};
            BDRE_A_STATUS: rdata_d = {5'h00, st_q, 2'h0, rx_current_desc_ptr_q,
               tx_current_desc_ptr_q};
            BDRE_A_MRBL: rdata_d = mrbl_q;
            default: rdata_d = BDRE_ZERO16;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= BDRE_IDLE;
         tx_current_desc_ptr_q <= '0;
         rx_current_desc_ptr_q <= '0;
         ctrl_w_q <= BDRE_ZERO16;
         len_q <= BDRE_ZERO16;
         cnt_q <= BDRE_ZERO16;
         bptr_q <= BDRE_ZERO16;
         rx_close_q <= 1'b0;
         rx_open_q <= 1'b0;
         rx_eof_q <= 1'b0;
         rx_fetch_q <= 1'b0;
         txv_q <= 1'b0;
         txl_q <= 1'b0;
         txd_q <= BDRE_ZERO16;
         ctl_q <= 2'b00;
         mask_q <= '0;
         ev_q <= '0;
         mrbl_q <= BDRE_MRBL_RST;
         rdata_q <= BDRE_ZERO16;
         cd_q <= 1'b0;
         cts_q <= 1'b0;
         rd_desc_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tx_current_desc_ptr_q <= tx_current_desc_ptr_d;
         rx_current_desc_ptr_q <= rx_current_desc_ptr_d;
         ctrl_w_q <= ctrl_w_d;
         len_q <= len_d;
         cnt_q <= cnt_d;
         bptr_q <= (st_q == BDRE_IDLE && !rx_open_q) ? BDRE_ZERO16 : bptr_d;
         rx_close_q <= rx_close_d;
         rx_open_q <= rx_open_d;
         rx_eof_q <= rx_eof_d;
         rx_fetch_q <= rx_fetch_d;
         txv_q <= txv_d;
         txl_q <= txl_d;
         txd_q <= txd_d;
         ctl_q <= ctl_d;
         mask_q <= mask_d;
         ev_q <= ev_d;
         mrbl_q <= mrbl_d;
         rdata_q <= rdata_d;
         cd_q <= carrier_detect;
         cts_q <= clear_to_send;
         rd_desc_q <= reg_rd && bus_desc;
      end
   end

   assign reg_rdata = rd_desc_q ? a_rdata : rdata_q;
   assign tx_out = '{valid: txv_q, data: txd_q, last: txl_q};
   assign irq = |(ev_q & mask_q);

   property p_irq;
      @(posedge clk) disable iff (sys_rst) irq == |(ev_q & mask_q);
   endproperty
   a_irq: assert property (p_irq) else $error("irq does not follow masked events");

   property p_w1c;
      @(posedge clk) disable iff (sys_rst)
         (reg_wr && reg_addr == BDRE_A_EVENT && reg_wdata[0] && !ev_set[0]) |=> !ev_q[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("event not cleared by one");

   property p_set_wins;
      @(posedge clk) disable iff (sys_rst) ev_set[BDRE_EV_TXB] |=> ev_q[BDRE_EV_TXB];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("transmit event lost");

   property p_tx_close;
      @(posedge clk) disable iff (sys_rst)
         (st_q == BDRE_TX_CLOSE) |-> bw_we && !b_wdata[BDRE_OWN_BIT];
   endproperty
   a_tx_close: assert property (p_tx_close) else $error("ready bit not cleared");

   property p_busy;
      @(posedge clk) disable iff (sys_rst)
         (st_q == BDRE_RX_WORD && !rx_open_q && !b_rdata[BDRE_OWN_BIT])
            |=> ev_q[BDRE_EV_BSY] && $stable(rx_current_desc_ptr_q);
   endproperty
   a_busy: assert property (p_busy) else $error("busy not flagged");

   property p_tx_adv;
      @(posedge clk) disable iff (sys_rst)
         (st_q == BDRE_TX_CLOSE && ctl_q[0]) |=>
            tx_current_desc_ptr_q == ($past(ctrl_w_q[BDRE_WRAP_BIT]) ? 3'd0
               : $past(tx_current_desc_ptr_q) + 3'd1);
   endproperty
   a_tx_adv: assert property (p_tx_adv) else $error("bad transmit advance");

   property p_no_skip;
      @(posedge clk) disable iff (sys_rst)
         (st_q == BDRE_TX_POLL && !b_rdata[BDRE_OWN_BIT]) |=> $stable(tx_current_desc_ptr_q);
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("descriptor skipped");

   property p_rx_close;
      @(posedge clk) disable iff (sys_rst)
         (st_q == BDRE_RX_CLOSE && rx_close_q) |-> bw_we && !b_wdata[BDRE_OWN_BIT];
   endproperty
   a_rx_close: assert property (p_rx_close) else $error("empty bit not cleared");
endmodule // bdre_engine

// ===== rtl/bdre_mem.sv
// Dual-port descriptor and buffer memory with registered read data.
`timescale 1ns/100ps
module bdre_mem
   import bdre_pkg::*;
#(
   parameter int AW = BDRE_MEM_AW
) (
   input wire logic clk,
   input wire logic a_we,
   input wire logic [AW-1:0] a_addr,
   input wire logic [15:0] a_wdata,
   output logic [15:0] a_rdata,
   input wire logic b_we,
   input wire logic [AW-1:0] b_addr,
   input wire logic [15:0] b_wdata,
   output logic [15:0] b_rdata
);
   logic [15:0] mem_q [0:(1<<AW)-1];
   always_ff @(posedge clk) begin
      if (a_we) begin
         mem_q[a_addr] <= a_wdata;
      end
      if (b_we) begin
         mem_q[b_addr] <= b_wdata;
      end
      a_rdata <= mem_q[a_addr];
      b_rdata <= mem_q[b_addr];
   end
endmodule // bdre_mem

// ===== testbench/bdre_chan_model.sv
// Serial channel model that feeds receive words and takes transmit words.
`timescale 1ns/100ps
module bdre_chan_model
   import bdre_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   output bdre_rx_t rx_in,
   input wire logic rx_ready,
   input wire bdre_tx_t tx_out,
   output logic tx_ready,
   input wire logic stall
);
   bdre_rx_t rx_q[$];
   logic [16:0] tx_got[$];
   task automatic push_rx(input logic [15:0] d, input logic eof, input logic err);
      rx_q.push_back('{valid: 1'b1, data: d, eof: eof, err: err});
   endtask
   assign tx_ready = !stall;
   // Words are held until taken; idle data keeps changing so it is never trusted.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_in <= '0;
      end else begin
         if (rx_in.valid && rx_ready) begin
            void'(rx_q.pop_front());
         end
         if (rx_q.size() > 0) begin
            rx_in <= rx_q[0];
         end else begin
            rx_in <= '{valid: 1'b0, data: ~rx_in.data, eof: 1'b0, err: 1'b0};
         end
         if (tx_out.valid && tx_ready) begin
            tx_got.push_back({tx_out.last, tx_out.data});
         end
      end
   end
endmodule // bdre_chan_model

// ===== testbench/bdre_engine_test.sv
// Self-checking testbench for the descriptor ring engine.
`timescale 1ns/100ps
module bdre_engine_test
   import bdre_pkg::*;
;
   logic clk, sys_rst, reg_wr, reg_rd, rx_ready, tx_ready, tx_err, irq, stall;
   logic carrier_detect, clear_to_send;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd;
   bdre_rx_t rx_in;
   bdre_tx_t tx_out;
   int n_mismatch, n_checks, cyc;
   bdre_engine bdre_engine_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_in(rx_in), .rx_ready(rx_ready), .tx_out(tx_out), .tx_ready(tx_ready),
      .tx_err(tx_err), .carrier_detect(carrier_detect), .clear_to_send(clear_to_send),
      .irq(irq));
   bdre_chan_model bdre_chan_model_i (.clk(clk), .sys_rst(sys_rst), .rx_in(rx_in),
      .rx_ready(rx_ready), .tx_out(tx_out), .tx_ready(tx_ready), .stall(stall));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         finish_test();
      end
   end
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] mem_a(input int w);
      return 8'h80 + 8'(2 * w);
   endfunction
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd_reg(a, d);
      chk16(d, exp);
   endtask
   task automatic wait_tx(input int n);
      for (int i = 0; i < 500 && bdre_chan_model_i.tx_got.size() < n; i++) @(posedge clk);
      wait_n(4);
      chk16(16'(bdre_chan_model_i.tx_got.size()), 16'(n));
   endtask
   task automatic wait_rx();
      for (int i = 0; i < 500 && bdre_chan_model_i.rx_q.size() > 0; i++) @(posedge clk);
      wait_n(10);
   endtask
   task automatic t_reset();
      chk1(irq, 1'b0);
      chk1(tx_out.valid, 1'b0);
      chk_reg(BDRE_A_STATUS, 16'h0000);
      chk_reg(BDRE_A_MRBL, BDRE_MRBL_RST);
      chk_reg(BDRE_A_EVENT, 16'h0000);
      chk_reg(8'h20, 16'h0000);
   endtask
   task automatic t_tx();
      for (int k = 0; k < 5; k++) wr(mem_a(16 + k), 16'h1100 + 16'(k));
      wr(mem_a(33), 16'h0004);
      wr(mem_a(34), 16'h0010);
      wr(mem_a(37), 16'h0006);
      wr(mem_a(38), 16'h0012);
      wr(mem_a(36), 16'hA000);
      wr(BDRE_A_CTRL, 16'h0001);
      wait_n(60);
      chk16(16'(bdre_chan_model_i.tx_got.size()), 16'h0000);
      @(posedge clk);
      stall <= 1'b1;
      wr(mem_a(32), 16'h8000);
      wait_n(30);
      chk1(tx_out.valid, 1'b1);
      chk16(tx_out.data, 16'h1100);
      @(posedge clk);
      stall <= 1'b0;
      wait_tx(5);
      for (int k = 0; k < 5; k++) begin
         chk16(bdre_chan_model_i.tx_got[k][15:0], 16'h1100 + 16'(k));
         chk1(bdre_chan_model_i.tx_got[k][16], k == 1 || k == 4);
      end
      chk_reg(mem_a(32), 16'h0000);
      chk_reg(mem_a(36), 16'h2000);
      chk_reg(BDRE_A_EVENT, 16'h0002);
      wr(mem_a(37), 16'h0000);
      wr(mem_a(32), 16'h8000);
      wait_tx(7);
      chk16(bdre_chan_model_i.tx_got[5][15:0], 16'h1100);
      chk1(bdre_chan_model_i.tx_got[6][16], 1'b1);
   endtask
   task automatic t_events();
      @(posedge clk);
      tx_err <= 1'b1;
      carrier_detect <= 1'b1;
      @(posedge clk);
      tx_err <= 1'b0;
      clear_to_send <= 1'b1;
      wait_n(3);
      chk_reg(BDRE_A_EVENT, 16'h0072);
      wr(BDRE_A_EVENT, 16'h0000);
      chk_reg(BDRE_A_EVENT, 16'h0072);
      wr(BDRE_A_EVENT, 16'h0010);
      chk_reg(BDRE_A_EVENT, 16'h0062);
      wr(BDRE_A_MASK, 16'h0020);
      chk1(irq, 1'b1);
      wr(BDRE_A_EVENT, 16'h0020);
      chk1(irq, 1'b0);
      wr(BDRE_A_EVENT, 16'hFFFF);
   endtask
   task automatic t_rx();
      wr(BDRE_A_MASK, 16'h0008);
      wr(mem_a(2), 16'h0018);
      wr(mem_a(6), 16'h001C);
      wr(mem_a(0), 16'h8000);
      wr(mem_a(4), 16'hA000);
      wr(BDRE_A_CTRL, 16'h0003);
      for (int k = 0; k < 4; k++) bdre_chan_model_i.push_rx(16'h2200 + 16'(k), 1'b0, 1'b0);
      wait_rx();
      chk_reg(mem_a(0), 16'h0000);
      chk_reg(mem_a(1), 16'h0008);
      for (int k = 0; k < 4; k++) chk_reg(mem_a(24 + k), 16'h2200 + 16'(k));
      rd_reg(BDRE_A_EVENT, rd);
      chk16(rd & 16'h0001, 16'h0001);
      chk1(irq, 1'b0);
      bdre_chan_model_i.push_rx(16'h3300, 1'b0, 1'b0);
      bdre_chan_model_i.push_rx(16'h3301, 1'b1, 1'b0);
      wait_rx();
      chk_reg(mem_a(4), 16'h2000);
      chk_reg(mem_a(5), 16'h0004);
      chk_reg(mem_a(29), 16'h3301);
      chk1(irq, 1'b1);
      wr(BDRE_A_EVENT, 16'hFFFF);
      chk1(irq, 1'b0);
      bdre_chan_model_i.push_rx(16'h4400, 1'b0, 1'b1);
      wait_n(40);
      chk16(16'(bdre_chan_model_i.rx_q.size()), 16'h0001);
      chk_reg(BDRE_A_EVENT, 16'h0004);
      wr(mem_a(1), 16'h0000);
      wr(mem_a(0), 16'h8000);
      wait_rx();
      chk16(16'(bdre_chan_model_i.rx_q.size()), 16'h0000);
      chk_reg(mem_a(0), 16'h0000);
      chk_reg(mem_a(24), 16'h4400);
   endtask
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      cyc = 0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_err = 1'b0;
      carrier_detect = 1'b0;
      clear_to_send = 1'b0;
      stall = 1'b0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      wait_n(1);
      t_reset();
      t_tx();
      t_events();
      t_rx();
      finish_test();
   end
endmodule // bdre_engine_test
